// ==== hdl/assp_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module assp_top (
   input wire logic SYS_CLK_I,
   input wire logic ARST_N_I,
   input wire assp_pkg::assp_req_t REG_REQ_I,
   output logic [assp_pkg::DATA_W-1:0] REG_RDATA_O,
   input wire logic RXD_I,
   output logic RXD_O,
   output logic RXD_OE_N_O,
   output logic TXD_O,
   output assp_pkg::assp_irq_t IRQ_O,
   output logic INT_O
);
   import assp_pkg::*;

   typedef struct packed {
      logic [CTRL_W-1:0] ctrl;
      logic [RELOAD_W-1:0] reload;
      logic [8:0] txbuf;
      logic txbuf_full;
      logic [8:0] rxbuf;
      logic rx_full;
      logic [ST_W-1:0] sts;
      logic [ST_W-1:0] msk;
      logic [DATA_W-1:0] rdata;
      logic [1:0] pre_cnt;
      logic [RELOAD_W-1:0] brg_cnt;
      logic rxd_meta;
      logic rxd_s;
      assp_tx_state_t tx_state;
      logic [12:0] tx_sh;
      logic [3:0] tx_bits;
      logic [3:0] tx_tick;
      logic sync_rx;
      logic txd;
      logic data_out;
      logic data_oe_n;
      assp_rx_state_t rx_state;
      logic [11:0] rx_sh;
      logic [3:0] rx_bits;
      logic [3:0] rx_tick;
      logic [2:0] rx_smp;
   } assp_state_t;

   assp_state_t s_q;
   assp_state_t s_d;

   logic rst_meta_q;
   logic rst_n_q;

   // ==========================================================
   // reset release
   // released on a clock edge so that every flop leaves reset on the same cycle
   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   // ==========================================================
   // next state
   always_comb begin
      logic [ST_W-1:0] ev;
      logic [ST_W-1:0] clr;
      logic tick;
      logic [3:0] nb;
      logic [3:0] tot;
      logic [3:0] rx_last;
      logic [12:0] frame;
      logic par;
      logic pbit;
      logic maj;
      logic pe;
      logic fe;
      logic [8:0] rx_data;
      logic [1:0] pre_last;

      s_d = s_q;
      ev = '0;
      clr = '0;
      tick = 1'b0;
      frame = '1;
      pe = 1'b0;
      fe = 1'b0;

      par = s_q.ctrl[CTRL_PAR_EN];
      nb = s_q.ctrl[CTRL_DATA9] ? 4'h9 : 4'h8;
      tot = 4'h1 + nb + {3'h0, par} + (s_q.ctrl[CTRL_STOP2] ? 4'h2 : 4'h1);
      rx_last = nb + {3'h0, par};
      pbit = ^s_q.txbuf[7:0] ^ (s_q.ctrl[CTRL_DATA9] & s_q.txbuf[8]) ^ s_q.ctrl[CTRL_PAR_ODD];
      maj = (s_q.rx_smp[0] & s_q.rx_smp[1]) | (s_q.rx_smp[0] & s_q.rx_smp[2])
         | (s_q.rx_smp[1] & s_q.rx_smp[2]);
      rx_data = s_q.ctrl[CTRL_DATA9] ? s_q.rx_sh[8:0] : {1'b0, s_q.rx_sh[7:0]};
      pre_last = PRESCALE_BASE - 2'h1 + {1'b0, s_q.ctrl[CTRL_PRESCALE]};

      // the line is asynchronous to this clock: two flops before any logic reads it
      s_d.rxd_meta = RXD_I;
      s_d.rxd_s = s_q.rxd_meta;

      // ==========================================================
      // dedicated baud generator: prescaler of 2 or 3, then reload down-counter
      // a new reload takes effect at the next wrap, so a rate change never cuts a tick short
      if (!s_q.ctrl[CTRL_RUN]) begin
         s_d.pre_cnt = 2'h0;
         s_d.brg_cnt = s_q.reload;
      end else if (s_q.pre_cnt == pre_last) begin
         s_d.pre_cnt = 2'h0;
         if (s_q.brg_cnt == '0) begin
            tick = 1'b1;
            s_d.brg_cnt = s_q.reload;
         end else begin
            s_d.brg_cnt = s_q.brg_cnt - 1'b1;
         end
      end else begin
         s_d.pre_cnt = s_q.pre_cnt + 2'h1;
      end

      // ==========================================================
      // transmitter, also the synchronous shift engine
      case (s_q.tx_state)
         TX_IDLE: begin
            if (s_q.ctrl[CTRL_RUN] && !s_q.ctrl[CTRL_SYNC] && s_q.txbuf_full) begin
               frame[0] = 1'b0;
               for (int i = 0; i < 9; i++) begin
                  if (4'(i) < nb) begin
                     frame[i+1] = s_q.txbuf[i];
                  end
               end
               if (par) begin
                  frame[nb+4'h1] = pbit;
               end

               s_d.tx_sh = frame;
               s_d.tx_bits = tot - 4'h1;
               s_d.tx_tick = 4'h0;
               s_d.txd = 1'b0;
               s_d.txbuf_full = 1'b0;
               ev[ST_TXB] = 1'b1;
               s_d.tx_state = TX_ASYNC;
               // in sync mode a waiting word is sent before any receive is started
            end else if (s_q.ctrl[CTRL_RUN] && s_q.ctrl[CTRL_SYNC] && s_q.txbuf_full) begin
               s_d.tx_sh = {5'h1f, s_q.txbuf[7:0]};
               s_d.tx_bits = SYNC_BITS - 4'h1;
               s_d.tx_tick = 4'h0;
               s_d.sync_rx = 1'b0;
               s_d.data_out = s_q.txbuf[0];
               s_d.data_oe_n = 1'b0;
               s_d.txbuf_full = 1'b0;
               ev[ST_TXB] = 1'b1;
               s_d.tx_state = TX_SYNC;
               // no word waiting: clock in one byte only if software asked for it
            end else if (s_q.ctrl[CTRL_RUN] && s_q.ctrl[CTRL_SYNC] && s_q.ctrl[CTRL_RX_EN]) begin
               s_d.tx_bits = SYNC_BITS - 4'h1;
               s_d.tx_tick = 4'h0;
               s_d.sync_rx = 1'b1;
               s_d.data_oe_n = 1'b1;
               s_d.tx_state = TX_SYNC;
            end
         end

         TX_ASYNC: begin
            if (tick) begin
               s_d.tx_tick = s_q.tx_tick + 4'h1;
               if (s_q.tx_tick == ASYNC_LAST_TICK) begin
                  if (s_q.tx_bits == 4'h0) begin
                     s_d.txd = 1'b1;
                     ev[ST_TX] = 1'b1;
                     s_d.tx_state = TX_IDLE;
                  end else begin
                     s_d.tx_sh = {1'b1, s_q.tx_sh[12:1]};
                     s_d.txd = s_q.tx_sh[1];
                     s_d.tx_bits = s_q.tx_bits - 4'h1;
                  end
               end
            end
         end

         TX_SYNC: begin
            // half duplex: direction is fixed for the whole byte
            if (tick) begin
               s_d.tx_tick = {2'h0, s_q.tx_tick[1:0] + 2'h1};
               case (s_q.tx_tick[1:0])
                  SYNC_CLK_LOW: begin
                     s_d.txd = 1'b0;
                  end

                  SYNC_CLK_HIGH: begin
                     s_d.txd = 1'b1;
                     if (s_q.sync_rx) begin
                        s_d.rx_sh[SYNC_BITS - 4'h1 - s_q.tx_bits] = s_q.rxd_s;
                     end
                  end

                  SYNC_LAST_TICK: begin
                     if (s_q.tx_bits == 4'h0) begin
                        s_d.data_oe_n = 1'b1;
                        s_d.data_out = 1'b1;
                        s_d.tx_state = TX_IDLE;
                        if (s_q.sync_rx) begin
                           s_d.rxbuf = {1'b0, s_d.rx_sh[7:0]};
                           ev[ST_RX] = 1'b1;
                           if (s_q.rx_full) begin
                              ev[ST_OE] = 1'b1;
                              ev[ST_ERR] = 1'b1;
                           end
                           s_d.rx_full = 1'b1;
                           s_d.ctrl[CTRL_RX_EN] = 1'b0;
                        end else begin
                           ev[ST_TX] = 1'b1;
                        end
                     end else begin
                        s_d.tx_sh = {1'b1, s_q.tx_sh[12:1]};
                        s_d.data_out = s_q.tx_sh[1];
                        s_d.tx_bits = s_q.tx_bits - 4'h1;
                     end
                  end

                  default: begin
                     s_d.txd = s_q.txd;
                  end
               endcase
            end
         end

         default: begin
            s_d.tx_state = TX_IDLE;
         end
      endcase

      // ==========================================================
      // asynchronous receiver, independent of the transmitter
      case (s_q.rx_state)
         RX_IDLE: begin
            if (s_q.ctrl[CTRL_RUN] && !s_q.ctrl[CTRL_SYNC] && s_q.ctrl[CTRL_RX_EN] && !s_q.rxd_s) begin
               s_d.rx_tick = 4'h0;
               s_d.rx_bits = 4'h0;
               s_d.rx_state = RX_START;
            end
         end

         RX_START, RX_DATA: begin
            if (tick) begin
               s_d.rx_tick = s_q.rx_tick + 4'h1;
               if (s_q.rx_tick == SAMPLE_A || s_q.rx_tick == SAMPLE_B || s_q.rx_tick == SAMPLE_C) begin
                  s_d.rx_smp = {s_q.rx_smp[1:0], s_q.rxd_s};
               end

               if (s_q.rx_tick == ASYNC_LAST_TICK) begin
                  if (s_q.rx_state == RX_START) begin
                     // a start bit that does not hold low is taken as a glitch
                     s_d.rx_state = maj ? RX_IDLE : RX_DATA;
                     // only the first stop bit is checked; a second one is left unsampled
                  end else if (s_q.rx_bits == rx_last) begin
                     fe = !maj;
                     if (par) begin
                        pe = (^rx_data) ^ s_q.ctrl[CTRL_PAR_ODD] ^ s_q.rx_sh[nb];
                     end

                     s_d.rxbuf = rx_data;
                     ev[ST_RX] = 1'b1;
                     ev[ST_PE] = pe;
                     ev[ST_FE] = fe;
                     ev[ST_OE] = s_q.rx_full;
                     ev[ST_ERR] = pe | fe | s_q.rx_full;

                     s_d.rx_full = 1'b1;
                     s_d.rx_state = RX_IDLE;
                  end else begin
                     s_d.rx_sh[s_q.rx_bits] = maj;
                     s_d.rx_bits = s_q.rx_bits + 4'h1;
                  end
               end
            end

            // stopping the generator or leaving async mode drops a frame in flight
            if (!s_q.ctrl[CTRL_RUN] || s_q.ctrl[CTRL_SYNC]) begin
               s_d.rx_state = RX_IDLE;
            end
         end

         default: begin
            s_d.rx_state = RX_IDLE;
         end
      endcase

      // ==========================================================
      // register port: writes come after the engines so a new word is kept
      s_d.rdata = '0;

      if (REG_REQ_I.wr) begin
         case (REG_REQ_I.addr)
            OFS_CTRL: s_d.ctrl = REG_REQ_I.wdata[CTRL_W-1:0];
            OFS_BAUD: s_d.reload = REG_REQ_I.wdata[RELOAD_W-1:0];
            OFS_TXBUF: begin
               s_d.txbuf = REG_REQ_I.wdata[8:0];
               s_d.txbuf_full = 1'b1;
            end
            OFS_STATUS: clr = REG_REQ_I.wdata[ST_W-1:0];
            OFS_MASK: s_d.msk = REG_REQ_I.wdata[ST_W-1:0];
            default: s_d.rdata = '0;
         endcase
      end

      if (REG_REQ_I.rd) begin
         case (REG_REQ_I.addr)
            OFS_CTRL: begin
               s_d.rdata[CTRL_W-1:0] = s_q.ctrl;
               s_d.rdata[CTRL_TX_BUSY] = (s_q.tx_state != TX_IDLE);
               s_d.rdata[CTRL_RX_BUSY] = (s_q.rx_state != RX_IDLE);
               s_d.rdata[CTRL_TXB_FULL] = s_q.txbuf_full;
               s_d.rdata[CTRL_RXB_FULL] = s_q.rx_full;
            end
            OFS_BAUD: s_d.rdata[RELOAD_W-1:0] = s_q.reload;
            OFS_TXBUF: s_d.rdata[8:0] = s_q.txbuf;
            OFS_RXBUF: begin
               s_d.rdata[8:0] = s_q.rxbuf;
               // a new word finished in this cycle keeps its full flag
               s_d.rx_full = ev[ST_RX];
            end
            OFS_STATUS: s_d.rdata[ST_W-1:0] = s_q.sts;
            OFS_MASK: s_d.rdata[ST_W-1:0] = s_q.msk;
            default: s_d.rdata = '0;
         endcase
      end

      // event beats a clear in the same cycle
      s_d.sts = (s_q.sts & ~clr) | ev;
   end

   // ==========================================================
   // state register
   always_ff @(posedge SYS_CLK_I or negedge rst_n_q) begin
      if (!rst_n_q) begin
         s_q <= '0;
         s_q.ctrl <= CTRL_RST;
         s_q.reload <= RELOAD_RST;
         s_q.msk <= MASK_RST;
         s_q.rxd_meta <= 1'b1;
         s_q.rxd_s <= 1'b1;
         s_q.tx_state <= TX_IDLE;
         s_q.rx_state <= RX_IDLE;
         s_q.tx_sh <= '1;
         // pins idle high in reset so the far side sees no false start bit
         s_q.txd <= 1'b1;
         s_q.data_out <= 1'b1;
         s_q.data_oe_n <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // outputs
   assign REG_RDATA_O = s_q.rdata;
   assign TXD_O = s_q.txd;
   assign RXD_O = s_q.data_out;
   assign RXD_OE_N_O = s_q.data_oe_n;

   assign IRQ_O.tx_done = s_q.sts[ST_TX] & s_q.msk[ST_TX];
   assign IRQ_O.tx_buffer = s_q.sts[ST_TXB] & s_q.msk[ST_TXB];
   assign IRQ_O.rx_done = s_q.sts[ST_RX] & s_q.msk[ST_RX];
   assign IRQ_O.rx_error = |(s_q.sts[ST_OE:ST_ERR] & s_q.msk[ST_OE:ST_ERR]);

   assign INT_O = |(s_q.sts & s_q.msk);

endmodule
`default_nettype wire

// ==== hdl/assp_pkg.sv ====
package assp_pkg;

   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;

   // ==========================================================
   // register offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_BAUD = 8'h04;
   localparam logic [7:0] OFS_TXBUF = 8'h08;
   localparam logic [7:0] OFS_RXBUF = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_MASK = 8'h14;

   // ==========================================================
   // control fields
   localparam int unsigned CTRL_W = 8;
   localparam int unsigned CTRL_SYNC = 0;
   localparam int unsigned CTRL_DATA9 = 1;
   localparam int unsigned CTRL_PAR_EN = 2;
   localparam int unsigned CTRL_STOP2 = 3;
   localparam int unsigned CTRL_PAR_ODD = 4;
   localparam int unsigned CTRL_RX_EN = 5;
   localparam int unsigned CTRL_PRESCALE = 6;
   localparam int unsigned CTRL_RUN = 7;
   localparam int unsigned CTRL_TX_BUSY = 8;
   localparam int unsigned CTRL_RX_BUSY = 9;
   localparam int unsigned CTRL_TXB_FULL = 10;
   localparam int unsigned CTRL_RXB_FULL = 11;
   localparam logic [7:0] CTRL_RST = 8'h00;

   // ==========================================================
   // status / mask fields
   localparam int unsigned ST_W = 7;
   localparam int unsigned ST_TX = 0;
   localparam int unsigned ST_TXB = 1;
   localparam int unsigned ST_RX = 2;
   localparam int unsigned ST_ERR = 3;
   localparam int unsigned ST_PE = 4;
   localparam int unsigned ST_FE = 5;
   localparam int unsigned ST_OE = 6;
   localparam logic [6:0] MASK_RST = 7'h00;

   // ==========================================================
   // baud generator and bit timing
   localparam int unsigned RELOAD_W = 13;
   localparam logic [12:0] RELOAD_RST = 13'h0000;
   localparam logic [1:0] PRESCALE_BASE = 2'h2;
   localparam logic [3:0] ASYNC_LAST_TICK = 4'hf;
   localparam logic [3:0] SAMPLE_A = 4'h6;
   localparam logic [3:0] SAMPLE_B = 4'h7;
   localparam logic [3:0] SAMPLE_C = 4'h8;
   localparam logic [1:0] SYNC_CLK_LOW = 2'h0;
   localparam logic [1:0] SYNC_CLK_HIGH = 2'h2;
   localparam logic [1:0] SYNC_LAST_TICK = 2'h3;
   localparam logic [3:0] SYNC_BITS = 4'h8;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } assp_req_t;

   typedef struct packed {
      logic tx_done;
      logic tx_buffer;
      logic rx_done;
      logic rx_error;
   } assp_irq_t;

   typedef enum logic [2:0] {
      TX_IDLE = 3'b001,
      TX_ASYNC = 3'b010,
      TX_SYNC = 3'b100
   } assp_tx_state_t;

   typedef enum logic [2:0] {
      RX_IDLE = 3'b001,
      RX_START = 3'b010,
      RX_DATA = 3'b100
   } assp_rx_state_t;

endpackage

// ==== verification/assp_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module assp_checker (
   input wire logic SYS_CLK_I,
   input wire logic ARST_N_I,
   input wire assp_pkg::assp_req_t REG_REQ_I,
   input wire logic [assp_pkg::DATA_W-1:0] REG_RDATA_O,
   input wire logic RXD_I,
   input wire logic RXD_O,
   input wire logic RXD_OE_N_O,
   input wire logic TXD_O,
   input wire assp_pkg::assp_irq_t IRQ_O,
   input wire logic INT_O
);
   import assp_pkg::*;
   logic [7:0] ctrl_q;
   logic [12:0] reload_q;
   logic [6:0] mask_q;
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (!ARST_N_I);
   // ==========================================================
   // shadows of software writes, so read-backs tie to their cause
   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         ctrl_q <= CTRL_RST;
         reload_q <= RELOAD_RST;
         mask_q <= MASK_RST;
      end else if (REG_REQ_I.wr) begin
         if (REG_REQ_I.addr == OFS_CTRL) ctrl_q <= REG_REQ_I.wdata[7:0];
         if (REG_REQ_I.addr == OFS_BAUD) reload_q <= REG_REQ_I.wdata[12:0];
         if (REG_REQ_I.addr == OFS_MASK) mask_q <= REG_REQ_I.wdata[6:0];
      end
   end
   // ==========================================================
   // properties
   a_int_level:
   assert property (INT_O == |IRQ_O) else $error("int output disagrees with irq lines");
   a_rdata_idle:
   assert property (!$past(REG_REQ_I.rd) |-> REG_RDATA_O == '0) else $error("read data outside read slot");
   a_mask_read:
   assert property ($past(REG_REQ_I.rd) && $past(REG_REQ_I.addr) == OFS_MASK |-> REG_RDATA_O == {25'h0, mask_q})
      else $error("mask read-back wrong");
   a_reload_read:
   assert property ($past(REG_REQ_I.rd) && $past(REG_REQ_I.addr) == OFS_BAUD |-> REG_RDATA_O == {19'h0, reload_q})
      else $error("reload read-back wrong");
   a_ctrl_read:
   assert property ($past(REG_REQ_I.rd) && $past(REG_REQ_I.addr) == OFS_CTRL
      |-> {REG_RDATA_O[7:6], REG_RDATA_O[4:0]} == {ctrl_q[7:6], ctrl_q[4:0]}) else $error("control read-back wrong");
   a_irq_masked:
   assert property (({IRQ_O.tx_done, IRQ_O.tx_buffer, IRQ_O.rx_done} & ~{mask_q[ST_TX], mask_q[ST_TXB],
      mask_q[ST_RX]}) == 3'h0) else $error("masked request raised");
   a_start_low:
   assert property ($fell(TXD_O) && !ctrl_q[CTRL_SYNC] |-> !TXD_O [*8]) else $error("async low bit too short");
   a_sync_clk_low:
   assert property ($fell(TXD_O) && ctrl_q[CTRL_SYNC] |-> !TXD_O [*4]) else $error("shift clock low too short");
   a_oe_sync_only:
   assert property (!RXD_OE_N_O |-> ctrl_q[CTRL_SYNC]) else $error("data pin driven outside sync mode");
   a_data_at_edge:
   assert property ($rose(TXD_O) && !RXD_OE_N_O |-> $stable(RXD_O) [*2]) else $error("data moved at shift edge");
endmodule
bind assp_top assp_checker chk_u (.SYS_CLK_I(SYS_CLK_I), .ARST_N_I(ARST_N_I), .REG_REQ_I(REG_REQ_I),
   .REG_RDATA_O(REG_RDATA_O), .RXD_I(RXD_I), .RXD_O(RXD_O), .RXD_OE_N_O(RXD_OE_N_O), .TXD_O(TXD_O),
   .IRQ_O(IRQ_O), .INT_O(INT_O));
`default_nettype wire

// ==== verification/assp_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
module assp_partner (
   input wire logic clk_i,
   input wire logic txd_i,
   input wire logic data_i,
   input wire logic oe_n_i,
   output logic line_o
);
   int bit_clks = 32;
   int flen = 10;
   int cyc = 0;
   int sidx = 8;
   logic sync_mode = 1'b0;
   logic drv = 1'b1;
   logic [7:0] srx = 8'h00;
   logic [11:0] sh;
   logic [11:0] cap_q[$];
   int rise_q[$];
   logic bits_q[$];
   // ==========================================================
   // shared data pin: device drive wins, else ours; idle level is high
   assign line_o = !oe_n_i ? data_i : drv;
   always @(posedge clk_i) cyc <= cyc + 1;
   task automatic send(input logic [11:0] f, input int n);
      for (int i = 0; i < n; i++) begin
         drv <= f[i];
         repeat (bit_clks) @(posedge clk_i);
      end
      drv <= 1'b1;
   endtask
   // ==========================================================
   // async capture at mid-bit, start bit included
   always begin
      @(negedge txd_i);
      if (!sync_mode) begin
         sh = '1;
         repeat (bit_clks / 2) @(posedge clk_i);
         for (int i = 0; i < flen; i++) begin
            sh[i] = txd_i;
            if (i < flen - 1) repeat (bit_clks) @(posedge clk_i);
         end
         cap_q.push_back(sh);
      end
   end
   // ==========================================================
   // sync mode: take data on the rising shift edge, feed ours on the falling one
   always @(posedge txd_i) if (sync_mode) begin
      rise_q.push_back(cyc);
      bits_q.push_back(data_i);
   end
   always @(negedge txd_i) if (sync_mode && oe_n_i && sidx < 8) begin
      drv <= srx[sidx];
      sidx <= sidx + 1;
   end
endmodule
`default_nettype wire

// ==== verification/assp_top_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
   $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module assp_top_test;
   import assp_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   assp_req_t req = '0;
   logic [DATA_W-1:0] rdata;
   logic rxd, rxd_o, oe_n, txd, intr;
   assp_irq_t irq;
   int mismatches = 0;
   int n_compared = 0;
   int cyc = 0;
   logic [31:0] d;
   logic [11:0] f;
   logic [8:0] dt, dr, m;
   logic [7:0] c;
   logic [7:0] sv = 8'ha5;
   logic [7:0] regs[5] = '{OFS_CTRL, OFS_BAUD, OFS_STATUS, OFS_MASK, 8'h18};
   logic [7:0] cfgs[5] = '{8'ha0, 8'ha2, 8'ha6, 8'hbc, 8'he0};
   logic [6:0] errs[3] = '{7'h1c, 7'h2c, 7'h4c};
   always #2.5 clk = ~clk;
   assp_top dut_u (.SYS_CLK_I(clk), .ARST_N_I(rst_n), .REG_REQ_I(req), .REG_RDATA_O(rdata), .RXD_I(rxd),
      .RXD_O(rxd_o), .RXD_OE_N_O(oe_n), .TXD_O(txd), .IRQ_O(irq), .INT_O(intr));
   assp_partner partner_u (.clk_i(clk), .txd_i(txd), .data_i(rxd_o), .oe_n_i(oe_n), .line_o(rxd));
   // ==========================================================
   // bus tasks; one idle cycle after each access keeps strobes single-driven
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      req <= '{a, v, 1'b1, 1'b0};
      @(posedge clk);
      req <= '0;
      @(posedge clk);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
      req <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge clk);
      req <= '0;
      @(negedge clk);
      d = rdata;
      `CHK(nm, e, d)
      @(posedge clk);
   endtask
   task automatic cfg(input logic [7:0] cv, input logic [12:0] r);
      wr(OFS_CTRL, 32'h0);
      wr(OFS_BAUD, {19'h0, r});
      wr(OFS_CTRL, {24'h0, cv});
      partner_u.bit_clks = 16 * (2 + cv[CTRL_PRESCALE]) * (r + 1);
      partner_u.flen = flen(cv);
      partner_u.sync_mode = cv[CTRL_SYNC];
   endtask
   function automatic int flen(input logic [7:0] cv);
      return 2 + (cv[CTRL_DATA9] ? 9 : 8) + cv[CTRL_PAR_EN] + cv[CTRL_STOP2];
   endfunction
   function automatic logic [11:0] frame(input logic [8:0] v, input logic [7:0] cv);
      logic p;
      frame = '1;
      frame[0] = 1'b0;
      p = cv[CTRL_PAR_ODD];
      for (int i = 0; i < 8 + cv[CTRL_DATA9]; i++) begin
         frame[i + 1] = v[i];
         p ^= v[i];
      end
      if (cv[CTRL_PAR_EN]) frame[9 + cv[CTRL_DATA9]] = p;
   endfunction
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         report_and_stop();
      end
   end
   // ==========================================================
   // tests
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      foreach (regs[i]) rdc(regs[i], 32'h0, "reset value");
      wr(OFS_RXBUF, 32'h1ff);
      rdc(OFS_RXBUF, 32'h0, "rxbuf write");
      wr(OFS_BAUD, 32'hffff_ffff);
      rdc(OFS_BAUD, 32'h1fff, "reload");
      `CHK("txd idle", 1'b1, txd)
      wr(OFS_MASK, 32'h7f);
      $display("test registers done");
      for (int k = 0; k < 5; k++) begin
         c = cfgs[k];
         cfg(c, 13'(k / 4));
         dt = 9'h15a - 9'(k);
         dr = ~dt;
         m = c[CTRL_DATA9] ? 9'h1ff : 9'h0ff;
         fork
            partner_u.send(frame(dr, c), flen(c));
         join_none
         wr(OFS_TXBUF, {23'h0, dt});
         if (k == 0) wr(OFS_TXBUF, {23'h0, dr});
         repeat ((2 * flen(c) + 2) * partner_u.bit_clks) @(posedge clk);
         f = partner_u.cap_q.pop_front();
         `CHK("tx frame", frame(dt, c), f)
         if (k == 0) f = partner_u.cap_q.pop_front();
         if (k == 0) `CHK("queued frame", frame(dr, c), f)
         rdc(OFS_RXBUF, {23'h0, dr & m}, "rx word");
         rdc(OFS_STATUS, 32'h07, "status");
         wr(OFS_STATUS, 32'h7f);
      end
      $display("test async frames done");
      cfg(8'ha4, 13'h0);
      partner_u.drv <= 1'b0;
      repeat (8) @(posedge clk);
      partner_u.drv <= 1'b1;
      repeat (400) @(posedge clk);
      rdc(OFS_STATUS, 32'h0, "short start");
      for (int k = 0; k < 3; k++) begin
         f = frame(9'h033, 8'ha4);
         if (k < 2) f[9 + k] = ~f[9 + k];
         partner_u.send(f, 11);
         if (k == 2) partner_u.send(f, 11);
         repeat (64) @(posedge clk);
         `CHK("error irq", 1'b1, irq.rx_error)
         rdc(OFS_STATUS, {25'h0, errs[k]}, "errors");
         wr(OFS_MASK, 32'h0);
         `CHK("masked int", 1'b0, intr)
         wr(OFS_MASK, 32'h7f);
         rdc(OFS_RXBUF, 32'h33, "error word");
         wr(OFS_STATUS, 32'h7f);
      end
      $display("test errors done");
      cfg(8'h81, 13'h0);
      partner_u.bits_q.delete();
      partner_u.rise_q.delete();
      wr(OFS_TXBUF, 32'ha5);
      repeat (100) @(posedge clk);
      `CHK("sync count", 8, partner_u.bits_q.size())
      for (int i = 0; i < 8; i++) begin
         `CHK("sync bit", sv[i], partner_u.bits_q[i])
         if (i > 0) `CHK("sync period", 8, partner_u.rise_q[i] - partner_u.rise_q[i - 1])
      end
      `CHK("oe released", 1'b1, oe_n)
      rdc(OFS_STATUS, 32'h03, "sync tx status");
      wr(OFS_STATUS, 32'h7f);
      partner_u.srx = 8'h96;
      partner_u.sidx = 0;
      wr(OFS_CTRL, 32'ha1);
      repeat (100) @(posedge clk);
      partner_u.drv <= 1'b1;
      rdc(OFS_RXBUF, 32'h96, "sync rx");
      rdc(OFS_CTRL, 32'h81, "rx enable cleared");
      rdc(OFS_STATUS, 32'h04, "sync rx status");
      $display("test sync done");
      report_and_stop();
   end
endmodule
`default_nettype wire
